// File: tb/adcc_cap.sv
// Downstream capture model for the sample output word
module adcc_cap (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] wt_i,
  input  wire logic [7:0] wc_i,
  input  wire logic       ft_i,
  input  wire logic       fc_i,
  input  wire logic       ot_i,
  input  wire logic       oc_i,
  output logic [7:0]      w_o,
  output int unsigned     n_o,
  output int unsigned     bad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic f_q;
  // Both edges of the forwarded clock mark a word
  always @(posedge clk_i) begin
    if (rst_i) begin
      f_q   <= 1'b0;
      w_o   <= 8'h00;
      n_o   <= 0;
      bad_o <= 0;
    end else begin
      f_q <= ft_i;
      if (ft_i !== f_q) begin
        w_o <= wt_i;
        n_o <= n_o + 1;
      end
      // Pairs checked only out of reset: outputs are unknown before it
      if ((wc_i !== ~wt_i) || (fc_i !== ~ft_i) ||
          (oc_i !== ~ot_i)) begin
        bad_o <= bad_o + 1;
      end
    end
  end
endmodule // adcc_cap

// File: tb/testbench.sv
// Self-checking bench for the sample output control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CAL = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] smp = 8'h11;
  logic ovr = 1'b0, und = 1'b0, rsel = 1'b0;
  logic hlv_n = 1'b1, tc_n = 1'b1, cal_n = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, r;
  logic [7:0] wt, wc, cw;
  logic ft, fc, ot, oc, rext, busy, irq, ack;
  int unsigned edges, perr, e0;
  int num_errors = 0, tests_run = 0;
  logic [10:0] tab [5] = '{11'h500, 11'h0da, 11'h27f, 11'h180, 11'h7ff};
  always #10 clk_i = ~clk_i;
  adcc_top #(.CAL_CYCLES(CAL)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .sample_i(smp), .sample_over_i(ovr), .sample_under_i(und),
    .reference_source_select_i(rsel), .clock_halve_select_n_i(hlv_n),
    .twos_comp_select_n_i(tc_n), .cal_reset_n_i(cal_n),
    .output_bit_true_o(wt), .output_bit_comp_o(wc),
    .forwarded_clock_true_o(ft), .forwarded_clock_comp_o(fc),
    .overrange_flag_true_o(ot), .overrange_flag_comp_o(oc),
    .reference_external_o(rext), .cal_busy_o(busy), .irq_o(irq),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack));
  adcc_cap i_cap (.clk_i(clk_i), .rst_i(rst_i), .wt_i(wt), .wc_i(wc),
    .ft_i(ft), .fc_i(fc), .ot_i(ot), .oc_i(oc), .w_o(cw), .n_o(edges),
    .bad_o(perr));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task tick(input int m);
    repeat (m) @(posedge clk_i);
    #1;
  endtask
  // Request stands until the edge that sees ack; data is taken there
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wd} <= {1'b1, 1'b1, w, a, d};
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    r = rd;
    {cyc, stb, we} <= 3'b000;
    #1;
  endtask
  task idle(input int m);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (busy !== 1'b0 && n < m);
    if (n >= m) chk(n, 32'h0);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole run is near 520 cycles; the limit leaves wide margin
  initial begin
    #200us;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk({ot, busy}, 2'b11);
    idle(CAL + 20);
    wb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0);
    wb(1'b1, 8'h0c, 32'h3);
    wb(1'b0, 8'h0c, 32'h0);
    chk(r, 32'h3);
    chk(rext, 1'b0);
    @(posedge clk_i);
    rsel <= 1'b1;
    smp <= 8'h5a;
    tick(40);
    chk({rext, wt, wc, cw}, 25'h15aa55a);
    wb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h5a0a);
    @(posedge clk_i);
    ovr <= 1'b1;
    tick(28);
    chk({ot, wt}, 9'h05a);
    tick(1);
    chk({ot, wt}, 9'h1ff);
    tick(3);
    chk(irq, 1'b1);
    wb(1'b1, 8'h0c, 32'h1);
    tick(3);
    chk(irq, 1'b0);
    @(posedge clk_i);
    ovr <= 1'b0;
    repeat (35) @(posedge clk_i);
    wb(1'b1, 8'h0c, 32'h3);
    tick(3);
    chk(irq, 1'b1);
    wb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h2);
    tick(3);
    chk(irq, 1'b0);
    // Entries: coding pin, over, under, expected word
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      {tc_n, ovr, und} <= tab[i][10:8];
      tick(40);
      chk(wt, tab[i][7:0]);
      chk(ot, tab[i][9] | tab[i][8]);
    end
    @(posedge clk_i);
    {tc_n, ovr, und} <= 3'b100;
    tick(4);
    e0 = edges;
    tick(20);
    chk(edges - e0, 32'h14);
    @(posedge clk_i);
    hlv_n <= 1'b0;
    tick(10);
    e0 = edges;
    tick(20);
    chk(edges - e0, 32'h0a);
    wb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h5a0e);
    @(posedge clk_i);
    hlv_n <= 1'b1;
    cal_n <= 1'b0;
    tick(6);
    chk({ft, ot}, 2'b01);
    e0 = edges;
    wb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h5a1b);
    chk(edges, e0);
    @(posedge clk_i);
    cal_n <= 1'b1;
    tick(5);
    chk({ot, busy}, 2'b11);
    idle(CAL + 20);
    tick(3);
    chk(ot, 1'b0);
    chk(edges > e0, 1'b1);
    wb(1'b1, 8'h00, 32'h1);
    tick(2);
    chk(busy, 1'b1);
    idle(CAL + 20);
    chk(perr, 32'h0);
    stop_test;
  end
endmodule // testbench

// File: verilog/adcc_pkg.sv
// Constants shared by the converter sample output control block
package adcc_pkg;
  localparam int unsigned WORD_W      = 8;
  localparam int unsigned LATENCY     = 28;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned CAL_TIME_MS = 190;
  localparam int unsigned CAL_CYCLES  = (CLK_HZ / 1000) * CAL_TIME_MS;
  localparam int unsigned CAL_CNT_W   = 24;
  // Wishbone register byte offsets
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_STATUS   = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;
  // Field positions
  localparam int unsigned CTRL_RECAL_BIT  = 0;
  localparam int unsigned ST_BUSY_BIT     = 0;
  localparam int unsigned ST_REF_EXT_BIT  = 1;
  localparam int unsigned ST_HALVE_BIT    = 2;
  localparam int unsigned ST_BINARY_BIT   = 3;
  localparam int unsigned ST_PIN_RST_BIT  = 4;
  localparam int unsigned ST_WORD_LSB     = 8;
  localparam int unsigned IRQ_CAL_BIT     = 0;
  localparam int unsigned IRQ_OVR_BIT     = 1;
  localparam int unsigned IRQ_W           = 2;
  // Reset values
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // Pin sync bits: 0 cal reset_n, 1 ref select, 2 halve_n, 3 twos_n
  localparam logic [3:0] PIN_SYNC_RST = 4'h9;
  localparam logic [7:0] CODE_MAX     = 8'hff;
  localparam logic [7:0] CODE_MIN     = 8'h00;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_CAL  = 3'b010,
    ST_RUN  = 3'b100
  } adcc_state_t;
endpackage : adcc_pkg

// File: verilog/adcc_top.sv
// Sample pipeline, output coding, calibration control and Wishbone regs
module adcc_top #(
  parameter int unsigned CAL_CYCLES = adcc_pkg::CAL_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  sample_i,
  input  wire logic        sample_over_i,
  input  wire logic        sample_under_i,
  input  wire logic        reference_source_select_i,
  input  wire logic        clock_halve_select_n_i,
  input  wire logic        twos_comp_select_n_i,
  input  wire logic        cal_reset_n_i,
  output logic [7:0]       output_bit_true_o,
  output logic [7:0]       output_bit_comp_o,
  output logic             forwarded_clock_true_o,
  output logic             forwarded_clock_comp_o,
  output logic             overrange_flag_true_o,
  output logic             overrange_flag_comp_o,
  output logic             reference_external_o,
  output logic             cal_busy_o,
  output logic             irq_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  localparam int unsigned W = adcc_pkg::WORD_W;
  localparam int unsigned L = adcc_pkg::LATENCY;
  localparam int unsigned CW = adcc_pkg::CAL_CNT_W;
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Pin synchronisers
  logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic       pin_rst_n, pin_ref, pin_halve_n, pin_twos_n;
  always_comb begin
    sync1_d = {twos_comp_select_n_i, clock_halve_select_n_i,
               reference_source_select_i, cal_reset_n_i};
    sync2_d = sync1_q;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= adcc_pkg::PIN_SYNC_RST;
      sync2_q <= adcc_pkg::PIN_SYNC_RST;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end
  assign pin_rst_n   = sync2_q[0];
  assign pin_ref     = sync2_q[1];
  assign pin_halve_n = sync2_q[2];
  assign pin_twos_n  = sync2_q[3];

  // Divider and calibration state
  adcc_pkg::adcc_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          div_q, div_d;
  logic          sample_en, soft_recal, cal_done;
  assign sample_en = pin_halve_n | div_q;
  assign cal_done  = (state_q == adcc_pkg::ST_CAL) && (cnt_q == CAL_LAST);
  always_comb begin
    div_d   = ~div_q;
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      adcc_pkg::ST_HOLD: begin
        cnt_d = '0;
        if (pin_rst_n) state_d = adcc_pkg::ST_CAL;
      end
      adcc_pkg::ST_CAL: begin
        cnt_d = cnt_q + CW'(1);
        if (cal_done) state_d = adcc_pkg::ST_RUN;
      end
      adcc_pkg::ST_RUN: begin
        cnt_d = '0;
        if (soft_recal) state_d = adcc_pkg::ST_CAL;
      end
      default: state_d = adcc_pkg::ST_HOLD;
    endcase
    // Pin reset low wins over everything, including a running calibration
    if (!pin_rst_n) begin
      state_d = adcc_pkg::ST_HOLD;
      cnt_d   = '0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= adcc_pkg::ST_CAL;
      cnt_q   <= '0;
      div_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      div_q   <= div_d;
    end
  end

  // Sample pipeline: bit W is the over-range mark
  logic [W:0] stage_q [L];
  logic [W:0] stage_d [L];
  logic [W-1:0] clamp_code;
  logic         in_ovr;
  logic [W:0]   stage_in;
  always_comb begin
    in_ovr = sample_over_i | sample_under_i;
    if (sample_over_i) clamp_code = adcc_pkg::CODE_MAX;
    else if (sample_under_i) clamp_code = adcc_pkg::CODE_MIN;
    else clamp_code = sample_i;
    stage_in = {in_ovr, clamp_code};
  end
  // Head of the chain is a net too, so every stage has one kind of driver
  assign stage_d[0] = sample_en ? stage_in : stage_q[0];
  for (genvar g = 1; g < L; g++) begin : g_pipe
    assign stage_d[g] = sample_en ? stage_q[g-1] : stage_q[g];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < L; i++) stage_q[i] <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  // Output drivers: every pin pair comes from its own flops
  logic [W-1:0] word_q, word_d, wordn_q, wordn_d;
  logic         ovr_q, ovr_d, ovrn_q, ovrn_d;
  logic         fclk_q, fclk_d, fclkn_q, fclkn_d;
  logic         ref_q, ref_d, busy_q, busy_d;
  logic [W-1:0] last_code;
  always_comb begin
    last_code = stage_q[L-1][W-1:0];
    // Flipping the MSB maps straight binary onto two's complement,
    // so clamped codes land on the matching full-scale codes
    if (!pin_twos_n) last_code[W-1] = ~last_code[W-1];
    word_d = sample_en ? last_code : word_q;
    ovr_d  = ovr_q;
    if (sample_en) ovr_d = stage_q[L-1][W];
    if (state_d != adcc_pkg::ST_RUN) ovr_d = 1'b1;
    fclk_d = sample_en ? ~fclk_q : fclk_q;
    if (state_d == adcc_pkg::ST_HOLD) fclk_d = 1'b0;
    wordn_d = ~word_d;
    ovrn_d  = ~ovr_d;
    fclkn_d = ~fclk_d;
    ref_d   = pin_ref;
    busy_d  = state_d != adcc_pkg::ST_RUN;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_q  <= '0;
      wordn_q <= '1;
      ovr_q   <= 1'b1;
      ovrn_q  <= 1'b0;
      fclk_q  <= 1'b0;
      fclkn_q <= 1'b1;
      ref_q   <= 1'b0;
      busy_q  <= 1'b1;
    end else begin
      word_q  <= word_d;
      wordn_q <= wordn_d;
      ovr_q   <= ovr_d;
      ovrn_q  <= ovrn_d;
      fclk_q  <= fclk_d;
      fclkn_q <= fclkn_d;
      ref_q   <= ref_d;
      busy_q  <= busy_d;
    end
  end
  assign output_bit_true_o      = word_q;
  assign output_bit_comp_o      = wordn_q;
  assign overrange_flag_true_o  = ovr_q;
  assign overrange_flag_comp_o  = ovrn_q;
  assign forwarded_clock_true_o = fclk_q;
  assign forwarded_clock_comp_o = fclkn_q;
  assign reference_external_o   = ref_q;
  assign cal_busy_o             = busy_q;

  // Wishbone slave, interrupt status and mask
  localparam int unsigned IW = adcc_pkg::IRQ_W;
  logic [IW-1:0] stat_q, stat_d, mask_q, mask_d, evt;
  logic [31:0]   dat_q, dat_d;
  logic          ack_q, ack_d, irq_q, irq_d, req, wr, rd;
  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_q;
    wr  = req & wb_we_i & wb_sel_i[0];
    rd  = req & ~wb_we_i;
    soft_recal = wr && (wb_adr_i == adcc_pkg::ADR_CTRL)
                 && wb_dat_i[adcc_pkg::CTRL_RECAL_BIT];
    evt = '0;
    evt[adcc_pkg::IRQ_CAL_BIT] = cal_done;
    evt[adcc_pkg::IRQ_OVR_BIT] = (state_q == adcc_pkg::ST_RUN) & sample_en
                                 & stage_q[L-1][W];
    ack_d  = req;
    dat_d  = '0;
    mask_d = mask_q;
    stat_d = stat_q;
    if (rd && wb_adr_i == adcc_pkg::ADR_IRQ_STAT) stat_d = '0;
    stat_d = stat_d | evt; // Set wins over the read clear
    if (wr && wb_adr_i == adcc_pkg::ADR_IRQ_MASK) mask_d = wb_dat_i[IW-1:0];
    if (rd) begin
      case (wb_adr_i)
        adcc_pkg::ADR_STATUS: begin
          dat_d[adcc_pkg::ST_BUSY_BIT]    = busy_q;
          dat_d[adcc_pkg::ST_REF_EXT_BIT] = pin_ref;
          dat_d[adcc_pkg::ST_HALVE_BIT]   = ~pin_halve_n;
          dat_d[adcc_pkg::ST_BINARY_BIT]  = pin_twos_n;
          dat_d[adcc_pkg::ST_PIN_RST_BIT] = ~pin_rst_n;
          dat_d[adcc_pkg::ST_WORD_LSB +: W] = word_q;
        end
        adcc_pkg::ADR_IRQ_STAT: dat_d[IW-1:0] = stat_q;
        adcc_pkg::ADR_IRQ_MASK: dat_d[IW-1:0] = mask_q;
        default: dat_d = '0;
      endcase
    end
    irq_d = |(stat_d & mask_d);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
      mask_q <= adcc_pkg::IRQ_MASK_RST;
      dat_q  <= '0;
      ack_q  <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      dat_q  <= dat_d;
      ack_q  <= ack_d;
      irq_q  <= irq_d;
    end
  end
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign irq_o    = irq_q;

  // Checks; a counter of back-to-back sample-enabled run cycles guards the latency checks
  logic [5:0] run_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !(sample_en && state_q == adcc_pkg::ST_RUN)) run_cnt_q <= '0;
    else if (run_cnt_q != 6'h3f) run_cnt_q <= run_cnt_q + 6'h01;
  end

  a_word_latency: assert property (
    (run_cnt_q >= 6'h1f && $past(pin_twos_n) && $past(pin_twos_n, 2))
    |-> word_q == $past(clamp_code, 29))
    else $error("data word latency wrong");
  a_flag_aligned: assert property (
    (run_cnt_q >= 6'h1f && state_q == adcc_pkg::ST_RUN)
    |-> ovr_q == $past(in_ovr, 29))
    else $error("over-range flag not aligned with word");
  a_ref_follow: assert property (
    (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3))
    |-> reference_external_o == $past(reference_source_select_i, 3))
    else $error("reference select not followed");
  a_halve_rate: assert property (
    (!pin_halve_n && sample_en) ##1 !pin_halve_n |-> !sample_en)
    else $error("halved clock enable twice in a row");
  a_hold_state: assert property (
    !pin_rst_n |=> state_q == adcc_pkg::ST_HOLD ##1 cal_busy_o)
    else $error("pin reset did not hold the converter");
  a_twos_msb: assert property (
    (sample_en && !pin_twos_n) |=> word_q[W-1] == ~$past(stage_q[L-1][W-1]))
    else $error("two's complement coding wrong");
  a_pair_comp: assert property (
    output_bit_comp_o == ~output_bit_true_o)
    else $error("data pair not complementary");
  a_fclk_pair: assert property (
    (sample_en && pin_rst_n && state_q == adcc_pkg::ST_RUN) |=>
    forwarded_clock_true_o != $past(forwarded_clock_true_o)
    && forwarded_clock_comp_o == ~forwarded_clock_true_o)
    else $error("forwarded clock did not toggle");
  a_flag_pair: assert property (
    overrange_flag_comp_o == ~overrange_flag_true_o)
    else $error("over-range pair not complementary");
  a_flag_forced: assert property (
    (state_q != adcc_pkg::ST_RUN) |-> overrange_flag_true_o)
    else $error("over-range not forced during calibration");
  a_clk_held: assert property (
    (state_q == adcc_pkg::ST_HOLD) [*2] |-> !forwarded_clock_true_o)
    else $error("output clock toggled in reset");
  a_clamp_top: assert property (
    (sample_en && sample_over_i && state_q == adcc_pkg::ST_RUN)
    |=> stage_q[0] == {1'b1, adcc_pkg::CODE_MAX})
    else $error("over-range input not clamped");
  c_cal_done: cover property (cal_done);
  c_ovr_irq: cover property (evt[adcc_pkg::IRQ_OVR_BIT] ##1 irq_o);
  c_recal: cover property (soft_recal ##1 state_q == adcc_pkg::ST_CAL);
endmodule : adcc_top
